// *** logic/irq_status_pkg.sv ***
package irq_status_pkg;
  // register offsets on the serial register port
  localparam logic [7:0] ADDR_EVT_SYS = 8'h01;
  localparam logic [7:0] ADDR_EVT_SW = 8'h02;
  localparam logic [7:0] ADDR_MASK_SYS = 8'h03;
  localparam logic [7:0] ADDR_MASK_SW = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h05;
  localparam logic [7:0] ADDR_CTRL = 8'h06;

  // reset values
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [5:0] EVT_RST = 6'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [1:0] CLASS_RST = 2'h0;
  localparam logic [1:0] PSTATE_RST = 2'h0;

  // system mask / event field positions
  localparam int PROG_VOLTAGE_BIT = 5;
  localparam int MAINS_CHANGE_BIT = 4;
  localparam int BUTTON_CHANGE_BIT = 3;
  localparam int OVERHEAT_BIT = 2;
  localparam int CELL_SAMPLE_DONE_BIT = 1;
  localparam int DEFAULTS_WRITTEN_BIT = 0;

  // load-switch mask / event field positions
  localparam int SWITCH_FAULT_LSB = 3;
  localparam int SWITCH_LIMIT_LSB = 0;

  // status field positions
  localparam int STAT_SEAL_BIT = 7;
  localparam int STAT_NVM_BIT = 6;
  localparam int STAT_MAINS_BIT = 5;
  localparam int STAT_BUTTON_BIT = 4;
  localparam int STAT_PSTATE_LSB = 2;
  localparam int STAT_CLASS_LSB = 0;

  // control field position
  localparam int CTRL_CELL_START_BIT = 0;

  // power state codes
  localparam logic [1:0] PSTATE_TRANSITION = 2'h0;
  localparam logic [1:0] PSTATE_AWAIT_ENABLE = 2'h1;
  localparam logic [1:0] PSTATE_ACTIVE = 2'h2;
  localparam logic [1:0] PSTATE_SUSPEND = 2'h3;

  // coin-cell charge classes
  localparam logic [1:0] CLASS_BELOW_LOW = 2'h0;
  localparam logic [1:0] CLASS_LOW = 2'h1;
  localparam logic [1:0] CLASS_GOOD = 2'h2;
  localparam logic [1:0] CLASS_IDEAL = 2'h3;

  // edges the pin synchroniser needs before its toggle output is trusted
  localparam logic [1:0] PIN_FILL = 2'h3;
endpackage : irq_status_pkg

// *** logic/pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module pin_sync
  import irq_status_pkg::*;
(
  input wire logic i_clk,     // system clock
  input wire logic i_rst_b,   // async reset, active low
  input wire logic i_ce,      // clock enable
  input wire logic i_pin,     // raw pin level
  output logic o_level,       // synchronised level
  output logic o_toggle       // one-cycle pulse on either edge
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [1:0] fill;
  } sync_s;

  sync_s st_r;
  sync_s st_nxt;

  // shift chain; s1 feeds s2 only, edges seen between s2 and s3
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.fill != PIN_FILL) begin
      st_nxt.fill = st_r.fill + 2'h1;
    end
  end

  // pins idle high; fill count hides the reset value from the edge check
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, fill: 2'h0};
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.s2;
  assign o_toggle = (st_r.fill == PIN_FILL) && (st_r.s2 != st_r.s3);
endmodule : pin_sync
`default_nettype wire

// *** logic/irq_mask_status.sv ***
// Function
// - unmasked pending event pulls interrupt low
// - masked event leaves interrupt untouched
// - masking never stops event recording
// - system mask layout, bits 7-6 zero
// - load-switch mask layout, bits 7-6 zero
// - masks reset zero at 0x03, 0x04
// - status bit 7 shows broken seal
// - status bit 6 shows modified defaults
// - status bit 5 shows mains pin low
// - status bit 4 shows button pin low
// - status bits 3-2 give power state
// - status bits 1-0 give cell class
// - status read-only at 0x05
// - mains pin toggle sets change flag
// - control bit 0 starts acquisition, self-clears
// - settled comparators set sample-done flag
`timescale 1ns/100ps
`default_nettype none
module irq_mask_status
  import irq_status_pkg::*;
(
  input wire logic i_clk,                // 100 MHz clock
  input wire logic i_rst_b,              // async reset, active low
  input wire logic i_ce,                 // clock enable, freezes all state
  input wire logic [7:0] i_reg_addr,     // register offset
  input wire logic [7:0] i_reg_wdata,    // write data
  input wire logic i_reg_wr,             // write strobe
  input wire logic i_reg_rd,             // read strobe
  output logic [7:0] o_reg_rdata,        // read data, registered
  output logic o_reg_rvalid,             // read data valid pulse
  input wire logic i_mains_detect_pin_b, // mains-detect pin, low active
  input wire logic i_button_pin_b,       // push-button pin, low active
  input wire logic i_prog_voltage_evt,   // programming voltage too low
  input wire logic i_overheat_evt,       // overheat warning
  input wire logic i_defaults_written_evt, // defaults programming done
  input wire logic [2:0] i_switch_fault_evt, // switch 3..1 fault
  input wire logic [2:0] i_switch_limit_evt, // switch 3..1 current limit
  input wire logic i_cell_settled,       // comparators settled pulse
  input wire logic [1:0] i_cell_class,   // comparator result
  input wire logic [1:0] i_power_state,  // power state machine code
  input wire logic i_seal_broken,        // freshness seal broken
  input wire logic i_nvm_changed,        // defaults differ from factory
  output logic o_cell_sample_start,      // acquisition start pulse
  output logic o_irq_out_low             // interrupt, active low
);
  typedef struct packed {
    logic [5:0] mask_sys;
    logic [5:0] mask_sw;
    logic [5:0] evt_sys;
    logic [5:0] evt_sw;
    logic seal;
    logic nvm;
    logic [1:0] pstate;
    logic [1:0] cclass;
    logic busy;
    logic start;
    logic [7:0] rdata;
    logic rvalid;
    logic irq_b;
  } ctl_s;

  ctl_s st_r;
  ctl_s st_nxt;
  logic mains_lvl;
  logic mains_tgl;
  logic button_lvl;
  logic button_tgl;
  logic [5:0] set_sys;
  logic [5:0] set_sw;
  logic rd_evt_sys;
  logic rd_evt_sw;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic pending(input logic [5:0] e, input logic [5:0] m);
    pending = |(e & ~m);
  endfunction : pending

  // both pins come from outside the clock domain
  pin_sync u_mains_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_pin(i_mains_detect_pin_b),
    .o_level(mains_lvl),
    .o_toggle(mains_tgl)
  );

  pin_sync u_button_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_pin(i_button_pin_b),
    .o_level(button_lvl),
    .o_toggle(button_tgl)
  );

  // event sources; recording ignores the masks entirely
  always_comb begin
    set_sys = 6'h00;
    set_sys[PROG_VOLTAGE_BIT] = i_prog_voltage_evt;
    set_sys[MAINS_CHANGE_BIT] = mains_tgl;
    set_sys[BUTTON_CHANGE_BIT] = button_tgl;
    set_sys[OVERHEAT_BIT] = i_overheat_evt;
    set_sys[CELL_SAMPLE_DONE_BIT] = st_r.busy && i_cell_settled;
    set_sys[DEFAULTS_WRITTEN_BIT] = i_defaults_written_evt;
    set_sw = {i_switch_fault_evt, i_switch_limit_evt};
  end

  assign rd_evt_sys = i_reg_rd && hit(i_reg_addr, ADDR_EVT_SYS);
  assign rd_evt_sw = i_reg_rd && hit(i_reg_addr, ADDR_EVT_SW);

  // next-state: registers, flags, status capture, read mux
  always_comb begin
    st_nxt = st_r;
    // read clears a flag register, a set in the same cycle wins
    st_nxt.evt_sys = set_sys | (rd_evt_sys ? EVT_RST : st_r.evt_sys);
    st_nxt.evt_sw = set_sw | (rd_evt_sw ? EVT_RST : st_r.evt_sw);
    st_nxt.seal = i_seal_broken;
    st_nxt.nvm = i_nvm_changed;
    st_nxt.pstate = i_power_state;
    st_nxt.start = 1'b0;
    if (st_r.busy && i_cell_settled) begin
      st_nxt.cclass = i_cell_class;
      st_nxt.busy = 1'b0;
    end
    if (i_reg_wr) begin
      if (hit(i_reg_addr, ADDR_MASK_SYS)) begin
        st_nxt.mask_sys = i_reg_wdata[5:0];
      end else if (hit(i_reg_addr, ADDR_MASK_SW)) begin
        st_nxt.mask_sw = i_reg_wdata[5:0];
      end else if (hit(i_reg_addr, ADDR_CTRL)) begin
        if (i_reg_wdata[CTRL_CELL_START_BIT]) begin
          st_nxt.start = 1'b1;
          st_nxt.busy = 1'b1;
        end
      end
      // status and flag registers ignore writes
    end
    st_nxt.rvalid = i_reg_rd;
    if (i_reg_rd) begin
      if (hit(i_reg_addr, ADDR_EVT_SYS)) begin
        st_nxt.rdata = {2'b00, st_r.evt_sys};
      end else if (hit(i_reg_addr, ADDR_EVT_SW)) begin
        st_nxt.rdata = {2'b00, st_r.evt_sw};
      end else if (hit(i_reg_addr, ADDR_MASK_SYS)) begin
        st_nxt.rdata = {2'b00, st_r.mask_sys};
      end else if (hit(i_reg_addr, ADDR_MASK_SW)) begin
        st_nxt.rdata = {2'b00, st_r.mask_sw};
      end else if (hit(i_reg_addr, ADDR_STATUS)) begin
        // pin bits invert: a low pin reads as active
        st_nxt.rdata = {st_r.seal, st_r.nvm, ~mains_lvl, ~button_lvl,
                        st_r.pstate, st_r.cclass};
      end else begin
        st_nxt.rdata = RDATA_RST; // control self-clears; unmapped reads zero
      end
    end
    // registered from next flags so the pin tracks flags without lag
    st_nxt.irq_b = !(pending(st_nxt.evt_sys, st_nxt.mask_sys) ||
                     pending(st_nxt.evt_sw, st_nxt.mask_sw));
  end

  // masks reset unmasked; live status bits start from defined zeros
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '{mask_sys: MASK_RST, mask_sw: MASK_RST,
                evt_sys: EVT_RST, evt_sw: EVT_RST,
                seal: 1'b0, nvm: 1'b0, pstate: PSTATE_RST,
                cclass: CLASS_RST, busy: 1'b0, start: 1'b0,
                rdata: RDATA_RST, rvalid: 1'b0, irq_b: 1'b1};
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_reg_rdata = st_r.rdata;
  assign o_reg_rvalid = st_r.rvalid;
  assign o_cell_sample_start = st_r.start;
  assign o_irq_out_low = st_r.irq_b;

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  logic rd_status_q;
  logic rd_mask_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_status_q <= 1'b0;
      rd_mask_q <= 1'b0;
    end else if (i_ce) begin
      rd_status_q <= i_reg_rd && hit(i_reg_addr, ADDR_STATUS);
      rd_mask_q <= i_reg_rd && (hit(i_reg_addr, ADDR_MASK_SYS) ||
                   hit(i_reg_addr, ADDR_MASK_SW));
    end
  end

  AST_UNMASKED_LOW: assert property (
    pending(st_r.evt_sys, st_r.mask_sys) ||
    pending(st_r.evt_sw, st_r.mask_sw) |-> !o_irq_out_low)
    else $error("unmasked pending flag but interrupt high");
  AST_MASKED_QUIET: assert property (
    !pending(st_r.evt_sys, st_r.mask_sys) &&
    !pending(st_r.evt_sw, st_r.mask_sw) |-> o_irq_out_low)
    else $error("interrupt low with nothing unmasked");
  AST_MASKED_RECORDED: assert property (
    i_ce && i_overheat_evt && st_r.mask_sys[OVERHEAT_BIT]
    |=> st_r.evt_sys[OVERHEAT_BIT])
    else $error("masked event was not recorded");
  AST_MASK_RSVD_ZERO: assert property (
    rd_mask_q |-> o_reg_rdata[7:6] == 2'b00)
    else $error("mask reserved bits not zero");
  AST_MASK_SW_WRITE: assert property (
    i_ce && i_reg_wr && hit(i_reg_addr, ADDR_MASK_SW)
    |=> st_r.mask_sw == $past(i_reg_wdata[5:0]))
    else $error("load-switch mask write lost");
  AST_STATUS_UPPER: assert property (
    rd_status_q |-> o_reg_rdata[7:6] == $past({st_r.seal, st_r.nvm}))
    else $error("status seal or nvm bit wrong");
  AST_MAINS_LEVEL: assert property (
    rd_status_q |-> o_reg_rdata[STAT_MAINS_BIT] == !$past(mains_lvl))
    else $error("mains level bit wrong");
  AST_BUTTON_LEVEL: assert property (
    rd_status_q |-> o_reg_rdata[STAT_BUTTON_BIT] == !$past(button_lvl))
    else $error("button level bit wrong");
  AST_STATE_CLASS: assert property (
    rd_status_q |-> o_reg_rdata[3:0] == $past({st_r.pstate, st_r.cclass}))
    else $error("power state or cell class wrong");
  AST_MAINS_TOGGLE: assert property (
    i_ce && mains_tgl |=> st_r.evt_sys[MAINS_CHANGE_BIT])
    else $error("mains toggle not flagged");
  AST_START_PULSE: assert property (
    i_ce && i_reg_wr && hit(i_reg_addr, ADDR_CTRL) &&
    i_reg_wdata[CTRL_CELL_START_BIT] ##1 i_ce
    |-> o_cell_sample_start ##1 !o_cell_sample_start)
    else $error("start bit did not self-clear");
  AST_DONE_FLAG: assert property (
    i_ce && st_r.busy && i_cell_settled
    |=> st_r.evt_sys[CELL_SAMPLE_DONE_BIT] && !st_r.busy)
    else $error("sample done flag not set");

  COV_IRQ_FALL: cover property ($fell(o_irq_out_low));
  COV_IRQ_RELEASE: cover property ($rose(o_irq_out_low));
  COV_CELL_DONE: cover property (
    o_cell_sample_start ##[1:50] st_r.evt_sys[CELL_SAMPLE_DONE_BIT]);
  COV_STATUS_READ: cover property (rd_status_q);
endmodule : irq_mask_status
`default_nettype wire

// *** verification/host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic i_clk,      // system clock
  output logic [7:0] o_addr,   // register offset
  output logic [7:0] o_wdata,  // write data
  output logic o_wr,           // write strobe
  output logic o_rd            // read strobe
);
  // idle port at time zero
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // one transfer; strobes drop low, released address and data show the inverse, never a stale value
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= wr;
    o_rd <= !wr;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : xfer
endmodule : host_model
`default_nettype wire

// *** verification/pmic_irq_mask_and_status_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmic_irq_mask_and_status_tb;
  import irq_status_pkg::*;
  logic clk, rst_b, wr, rd, rvalid, mains_b, button_b, prog, hot, dflt;
  logic settled, seal, nvm, start, irq_b;
  logic [7:0] addr, wdata, rdata, ma, fa;
  logic [2:0] fault, limit;
  logic [1:0] cls, pstate;
  logic [5:0] m;
  logic [31:0] rng;
  logic [7:0] exp_q[$];
  int error_cnt, total_checks, i, b;

  host_model u_host_model (.i_clk(clk), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));
  irq_mask_status u_irq_mask_status (.i_clk(clk), .i_rst_b(rst_b),
    .i_ce(1'b1), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_mains_detect_pin_b(mains_b), .i_button_pin_b(button_b),
    .i_prog_voltage_evt(prog), .i_overheat_evt(hot),
    .i_defaults_written_evt(dflt), .i_switch_fault_evt(fault),
    .i_switch_limit_evt(limit), .i_cell_settled(settled),
    .i_cell_class(cls), .i_power_state(pstate), .i_seal_broken(seal),
    .i_nvm_changed(nvm), .o_cell_sample_start(start),
    .o_irq_out_low(irq_b));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // expectation is queued before the strobe goes out
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host_model.xfer(1'b0, a, 8'h00);
  endtask : rd_exp

  // pulse one event source, or toggle its pin, then let it settle
  task automatic fire(input int n);
    @(posedge clk);
    case (n)
      0: dflt <= 1'b1;
      2: hot <= 1'b1;
      3: button_b <= ~button_b;
      4: mains_b <= ~mains_b;
      5: prog <= 1'b1;
      default: {fault, limit} <= 6'h01 << (n - 6);
    endcase
    @(posedge clk);
    {prog, hot, dflt} <= 3'h0;
    {fault, limit} <= 6'h00;
    repeat (3) @(posedge clk);
  endtask : fire

  task automatic conclude;
    // a read that never got its valid pulse is a failure too
    if (exp_q.size() > 0) begin
      error_cnt++;
      $display("Error at %0t: %0d reads never answered", $time, exp_q.size());
    end
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // read monitor: oldest note against each valid pulse
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() > 0) check(rdata, exp_q.pop_front());
      else begin
        error_cnt++;
        $display("Error at %0t: unexpected read data", $time);
      end
    end
  end

  // watchdog sized well above the few hundred cycles needed
  initial begin
    #200000;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    rng = 32'h000142fd;
    {rst_b, mains_b, button_b, prog, hot, dflt, settled} = 7'h30;
    {fault, limit, cls, pstate, seal, nvm} = 12'h000;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd_exp(ADDR_MASK_SYS, 8'h00);
    rd_exp(ADDR_MASK_SW, 8'h00);
    rd_exp(8'h20, 8'h00);
    @(negedge clk);
    check({7'h00, irq_b}, 8'h01);
    $display("test reset values done");
    // two rounds so each pin toggles both ways
    for (int n = 0; n < 24; n++) begin
      i = n % 12;
      b = i % 6;
      if (i == 1) continue;
      rng = xs(rng);
      m = rng[5:0];
      m[b] = (n >= 12); // round one unmasked, round two masked
      ma = (i < 6) ? ADDR_MASK_SYS : ADDR_MASK_SW;
      fa = (i < 6) ? ADDR_EVT_SYS : ADDR_EVT_SW;
      u_host_model.xfer(1'b1, ma, {2'b11, m});
      fire(i);
      @(negedge clk);
      check({7'h00, irq_b}, {7'h00, m[b]});
      rd_exp(ma, {2'b00, m});
      rd_exp(fa, 8'h01 << b);
      @(negedge clk);
      check({7'h00, irq_b}, 8'h01);
    end
    $display("test mask and events done");
    u_host_model.xfer(1'b1, ADDR_MASK_SYS, 8'h00);
    for (int c = 0; c < 4; c++) begin
      rng = xs(rng);
      pstate <= c[1:0];
      {seal, nvm} <= rng[1:0];
      u_host_model.xfer(1'b1, ADDR_CTRL, 8'h01);
      @(negedge clk);
      check({7'h00, start}, 8'h01);
      @(negedge clk);
      check({7'h00, start}, 8'h00);
      @(posedge clk);
      settled <= 1'b1;
      cls <= c[1:0];
      @(posedge clk);
      settled <= 1'b0;
      @(negedge clk);
      check({7'h00, irq_b}, 8'h00);
      rd_exp(ADDR_CTRL, 8'h00);
      rd_exp(ADDR_EVT_SYS, 8'h02);
      u_host_model.xfer(1'b1, ADDR_STATUS, 8'hff);
      rd_exp(ADDR_STATUS, {rng[1:0], ~mains_b, ~button_b, c[1:0],
        c[1:0]});
    end
    repeat (2) @(posedge clk);
    $display("test acquisition and status done");
    conclude();
  end
endmodule : pmic_irq_mask_and_status_tb
`default_nettype wire
